/* verilog/tpp_timer_pulse.sv */
// Timer channel with compare pins, acting as time base for a 4-bit pulse group.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module tpp_timer_pulse
  import tpp_pkg::*;
#(
  parameter int GRP_W  = 4,
  parameter int CNT_W  = 16,
  parameter int PSC_W  = 6
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              capture_in_a,
  input  wire logic              capture_in_b,
  output logic                   timer_pin_a,
  output logic                   timer_pin_a_oe,
  output logic                   timer_pin_b,
  output logic                   timer_pin_b_oe,
  output logic [GRP_W-1:0]       pulse_out,
  output logic [GRP_W-1:0]       pulse_out_oe,
  output logic                   match_a_irq_request
);

  tpp_bus_e          bus_state;
  logic [7:0]        output_trigger_select;
  logic [7:0]        output_mode_control;
  logic [7:0]        next_value_enable_high;
  logic [7:0]        next_value_enable_low;
  logic [7:0]        pulse_output_value_low;
  logic [7:0]        pending_output_value_low;
  logic [7:0]        counter_run_control;
  logic [7:0]        counter_sync_control;
  logic [7:0]        counter_clock_control;
  logic [7:0]        counter_operating_mode;
  logic [7:0]        compare_pin_control_ab;
  logic [7:0]        compare_pin_control_cd;
  logic [7:0]        counter_irq_enable;
  logic [1:0]        match_flag;
  logic [1:0]        flag_read_one;
  logic [CNT_W-1:0]  channel_counter;
  logic [CNT_W-1:0]  general_reg [2];
  logic [PSC_W-1:0]  psc_cnt;
  logic [1:0]        cap_prev;
  logic [1:0]        pin_level;
  logic              wr_fire;
  logic              rd_take;
  logic [23:0]       idx;
  logic              idx_ok;
  logic              count_tick;
  logic [PSC_W-1:0]  psc_mask;
  logic [1:0]        cmp_match;
  logic [1:0]        cap_event;
  logic [1:0]        gr_event;
  logic [3:0]        ioc [2];
  logic [2:0]        counter_clear_select;
  logic [1:0]        count_edge_select;
  logic [2:0]        prescale_select;
  logic              counter_run_bit;
  logic              group_trigger_own;
  logic              groups_share;
  logic              byte_ok;
  logic [7:0]        wbyte;
  logic [31:0]       next_rdata;
  logic              next_err;
  logic [GRP_W-1:0]  grp_en;
  logic [GRP_W-1:0]  grp_next;
  logic [GRP_W-1:0]  grp_cur;
  assign grp_en   = next_value_enable_low[GRP_LO_LSB +: GRP_W];
  assign grp_next = pending_output_value_low[GRP_LO_LSB +: GRP_W];
  assign grp_cur  = pulse_output_value_low[GRP_LO_LSB +: GRP_W];
  assign counter_clear_select = counter_clock_control[CLR_LSB +: 3];
  assign count_edge_select    = counter_clock_control[EDGE_LSB +: 2];
  assign prescale_select      = counter_clock_control[PSC_LSB +: 3];
  assign counter_run_bit      = counter_run_control[RUN_BIT];
  assign ioc[0] = compare_pin_control_ab[PIN_A_LSB +: 4];
  assign ioc[1] = compare_pin_control_ab[PIN_B_LSB +: 4];
  assign group_trigger_own =
    output_trigger_select[GRP_LO_LSB +: 2] == TRIG_OWN;
  assign groups_share = output_trigger_select[GRP_LO_LSB +: 2] ==
                        output_trigger_select[GRP_HI_LSB - 2 +: 2];
  // The bus word index sits above the two byte-offset bits.
  assign idx     = paddr[25:2];
  assign idx_ok  = paddr[31:26] == 6'h00 && paddr[1:0] == 2'h0;
  assign wr_fire = psel && penable && pready && pwrite && !pslverr;
  assign rd_take = psel && penable && !pwrite && bus_state == TPP_ACCESS;
  assign wbyte   = pwdata[7:0];
  assign byte_ok = pstrb[0];
  // The slave answers one cycle into the access phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_state <= TPP_IDLE;
    else if (psel && penable && bus_state == TPP_ACCESS)
      bus_state <= TPP_DONE;
    else if (psel && !penable)
      bus_state <= TPP_ACCESS;
    else
      bus_state <= TPP_IDLE;
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (!idx_ok)
      next_err = 1'b1;
    else
      case (idx)
        IDX_TRIG_SEL:  next_rdata[7:0] = output_trigger_select;
        IDX_MODE_CTL:  next_rdata[7:0] = output_mode_control;
        IDX_NEN_HIGH:  next_rdata[7:0] = next_value_enable_high;
        IDX_NEN_LOW:   next_rdata[7:0] = next_value_enable_low;
        IDX_OUT_LOW:   next_rdata[7:0] = pulse_output_value_low;
        IDX_NEXT_LOW:  next_rdata[7:0] = pending_output_value_low;
        IDX_NEXT_ALT:  next_rdata[7:0] = pending_output_value_low;
        IDX_RUN_CTL:   next_rdata[7:0] = counter_run_control;
        IDX_SYNC_CTL:  next_rdata[7:0] = counter_sync_control;
        IDX_CLK_CTL:   next_rdata[7:0] = counter_clock_control;
        IDX_OP_MODE:   next_rdata[7:0] = counter_operating_mode;
        IDX_PIN_AB:    next_rdata[7:0] = compare_pin_control_ab;
        IDX_PIN_CD:    next_rdata[7:0] = compare_pin_control_cd;
        IDX_IRQ_EN:    next_rdata[7:0] = counter_irq_enable;
        IDX_FLAGS:     next_rdata[7:0] = {6'h00, match_flag};
        IDX_COUNT:     next_rdata[15:0] = channel_counter;
        IDX_CMP_A:     next_rdata[15:0] = general_reg[0];
        IDX_CMP_B:     next_rdata[15:0] = general_reg[1];
        default:       next_err = 1'b1;
      endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && penable && bus_state == TPP_ACCESS;
      pslverr <= psel && penable && bus_state == TPP_ACCESS && next_err;
      prdata  <= rd_take && !next_err ? next_rdata : 32'h0000_0000;
    end
  end

  function automatic logic hit(input logic [23:0] want);
    hit = wr_fire && byte_ok && idx == want;
  endfunction
  // Plain control registers. Buffer, mode and sync fields are held only:
  // zero codes give solo registers, normal counting and a free channel.
  // Buffer bits stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      output_trigger_select  <= RST_BYTE;
      output_mode_control    <= RST_MODE;
      next_value_enable_high <= RST_BYTE;
      next_value_enable_low  <= RST_BYTE;
      counter_run_control    <= RST_BYTE;
      counter_sync_control   <= RST_BYTE;
      counter_clock_control  <= RST_BYTE;
      counter_operating_mode <= RST_BYTE;
      compare_pin_control_ab <= RST_BYTE;
      compare_pin_control_cd <= RST_BYTE;
      counter_irq_enable     <= RST_BYTE;
    end
    else
    begin
      if (hit(IDX_TRIG_SEL))
        output_trigger_select <= wbyte;
      if (hit(IDX_MODE_CTL))
        output_mode_control <= wbyte;
      if (hit(IDX_NEN_HIGH))
        next_value_enable_high <= wbyte;
      if (hit(IDX_NEN_LOW))
        next_value_enable_low <= wbyte;
      if (hit(IDX_RUN_CTL))
        counter_run_control <= wbyte;
      if (hit(IDX_SYNC_CTL))
        counter_sync_control <= wbyte;
      if (hit(IDX_CLK_CTL))
        counter_clock_control <= wbyte;
      if (hit(IDX_OP_MODE))
        counter_operating_mode <= wbyte;
      if (hit(IDX_PIN_AB))
        compare_pin_control_ab <= wbyte;
      if (hit(IDX_PIN_CD))
        compare_pin_control_cd <= wbyte;
      if (hit(IDX_IRQ_EN))
        counter_irq_enable <= wbyte;
    end
  end
  // Prescaler: a free divider; the code picks a divide of 1, 4, 16 or 64.
  always_comb
  begin
    case (prescale_select)
      3'h0:    psc_mask = 6'h00;
      3'h1:    psc_mask = 6'h03;
      3'h2:    psc_mask = 6'h0f;
      default: psc_mask = 6'h3f;
    endcase
  end
  always_comb
  begin
    if (psc_mask == 6'h00)
      count_tick = 1'b1;
    else if (count_edge_select == EDGE_FALL)
      count_tick = (psc_cnt & psc_mask) == psc_mask;
    else if (count_edge_select == EDGE_RISE)
      count_tick = (psc_cnt & psc_mask) == (psc_mask >> 1) + 6'h01;
    else
      count_tick = (psc_cnt & (psc_mask >> 1)) == (psc_mask >> 1);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      psc_cnt <= '0;
    else
      psc_cnt <= psc_cnt + 6'h01;
  end
  // Compare and capture per general register.
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_gr
      assign cmp_match[g] = counter_run_bit && count_tick &&
                            !ioc[g][IOC_CAP_BIT] &&
                            channel_counter == general_reg[g];
      assign cap_event[g] = ioc[g][IOC_CAP_BIT] &&
                            (g == 0 ? capture_in_a : capture_in_b) &&
                            !cap_prev[g];
      assign gr_event[g]  = cmp_match[g] || cap_event[g];

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          general_reg[g] <= RST_WORD;
          pin_level[g]   <= 1'b0;
          cap_prev[g]    <= 1'b0;
          match_flag[g]  <= 1'b0;
          flag_read_one[g] <= 1'b0;
        end
        else
        begin
          cap_prev[g] <= g == 0 ? capture_in_a : capture_in_b;
          if (cap_event[g])
            general_reg[g] <= channel_counter;
          else if (hit(g == 0 ? IDX_CMP_A : IDX_CMP_B))
            general_reg[g] <= pwdata[CNT_W-1:0];
          if (hit(IDX_PIN_AB))
            pin_level[g] <= wbyte[(g == 0 ? PIN_A_LSB : PIN_B_LSB)
                                  + IOC_INI_BIT];
          else if (cmp_match[g])
            case (ioc[g][1:0])
              ACT_LOW:    pin_level[g] <= 1'b0;
              ACT_HIGH:   pin_level[g] <= 1'b1;
              ACT_TOGGLE: pin_level[g] <= !pin_level[g];
              default:    pin_level[g] <= pin_level[g];
            endcase
          if (rd_take && idx_ok && idx == IDX_FLAGS)
            flag_read_one[g] <= match_flag[g];
          if (gr_event[g])
            match_flag[g] <= 1'b1;
          else if (hit(IDX_FLAGS) && !wbyte[g] && flag_read_one[g])
          begin
            match_flag[g]    <= 1'b0;
            flag_read_one[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  // Counter: a bus write wins over counting, clearing wins over stepping.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_counter <= RST_WORD;
    else if (hit(IDX_COUNT))
      channel_counter <= pwdata[CNT_W-1:0];
    else if (counter_clear_select == CLR_ON_B && gr_event[1])
      channel_counter <= RST_WORD;
    else if (counter_clear_select == CLR_ON_A && gr_event[0])
      channel_counter <= RST_WORD;
    else if (counter_run_bit && count_tick)
      channel_counter <= channel_counter + 16'h0001;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pending_output_value_low <= RST_BYTE;
    else if (hit(IDX_NEXT_LOW) && groups_share)
      pending_output_value_low <= wbyte;
    else if (hit(IDX_NEXT_LOW))
      pending_output_value_low[GRP_HI_LSB +: GRP_W] <=
        wbyte[GRP_HI_LSB +: GRP_W];
    else if (hit(IDX_NEXT_ALT) && !groups_share)
      pending_output_value_low[GRP_LO_LSB +: GRP_W] <=
        wbyte[GRP_LO_LSB +: GRP_W];
  end
  // Output data: held until the trigger; software may preset it any time.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_output_value_low <= RST_BYTE;
    else if (hit(IDX_OUT_LOW))
      pulse_output_value_low <= wbyte;
    else if (group_trigger_own && cmp_match[0])
      pulse_output_value_low[GRP_LO_LSB +: GRP_W] <=
        (grp_cur & ~grp_en) | (grp_next & grp_en);
    else if (group_trigger_own && cmp_match[1] &&
             output_mode_control[NOV_BIT])
      pulse_output_value_low[GRP_LO_LSB +: GRP_W] <=
        grp_cur & ~(grp_en & ~grp_next);
  end
  // Registered pin and request outputs.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_pin_a         <= 1'b0;
      timer_pin_a_oe      <= 1'b0;
      timer_pin_b         <= 1'b0;
      timer_pin_b_oe      <= 1'b0;
      pulse_out           <= '0;
      pulse_out_oe        <= '0;
      match_a_irq_request <= 1'b0;
    end
    else
    begin
      timer_pin_a    <= pin_level[0];
      timer_pin_a_oe <= !ioc[0][IOC_CAP_BIT] && ioc[0] != 4'h0;
      timer_pin_b    <= pin_level[1];
      timer_pin_b_oe <= !ioc[1][IOC_CAP_BIT] && ioc[1] != 4'h0;
      pulse_out <= output_mode_control[INV_BIT]
        ? pulse_output_value_low[GRP_LO_LSB +: GRP_W]
        : ~pulse_output_value_low[GRP_LO_LSB +: GRP_W];
      pulse_out_oe <= next_value_enable_low[GRP_LO_LSB +: GRP_W];
      match_a_irq_request <= match_flag[FLAG_A_BIT] &&
                             counter_irq_enable[IRQ_A_BIT];
    end
  end

endmodule // tpp_timer_pulse

/* verilog/tpp_pkg.sv */
// Constants, register indices and field codes for the timer paced pulse block.
package tpp_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [23:0] IDX_TRIG_SEL   = 24'hfff636;
  localparam logic [23:0] IDX_MODE_CTL   = 24'hfff637;
  localparam logic [23:0] IDX_NEN_HIGH   = 24'hfff638;
  localparam logic [23:0] IDX_NEN_LOW    = 24'hfff639;
  localparam logic [23:0] IDX_OUT_LOW    = 24'hfff63b;
  localparam logic [23:0] IDX_NEXT_LOW   = 24'hfff63d;
  localparam logic [23:0] IDX_NEXT_ALT   = 24'hfff63f;
  localparam logic [23:0] IDX_RUN_CTL    = 24'hfffb00;
  localparam logic [23:0] IDX_SYNC_CTL   = 24'hfffb01;
  localparam logic [23:0] IDX_CLK_CTL    = 24'hfffb10;
  localparam logic [23:0] IDX_OP_MODE    = 24'hfffb11;
  localparam logic [23:0] IDX_PIN_AB     = 24'hfffb12;
  localparam logic [23:0] IDX_PIN_CD     = 24'hfffb13;
  localparam logic [23:0] IDX_IRQ_EN     = 24'hfffb14;
  localparam logic [23:0] IDX_FLAGS      = 24'hfffb15;
  localparam logic [23:0] IDX_COUNT      = 24'hfffb16;
  localparam logic [23:0] IDX_CMP_A      = 24'hfffb18;
  localparam logic [23:0] IDX_CMP_B      = 24'hfffb1a;
  localparam logic [7:0]  IDX_PAD        = 8'h00;

  // Field positions.
  localparam int RUN_BIT     = 0;
  localparam int FLAG_A_BIT  = 0;
  localparam int FLAG_B_BIT  = 1;
  localparam int IRQ_A_BIT   = 0;
  localparam int INV_BIT     = 4;
  localparam int NOV_BIT     = 0;
  localparam int CLR_LSB     = 5;
  localparam int EDGE_LSB    = 3;
  localparam int PSC_LSB     = 0;
  localparam int PIN_B_LSB   = 4;
  localparam int PIN_A_LSB   = 0;
  localparam int GRP_LO_LSB  = 0;
  localparam int GRP_HI_LSB  = 4;
  localparam int IOC_CAP_BIT = 3;
  localparam int IOC_INI_BIT = 2;

  // Reset values.
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  RST_MODE   = 8'hf0;
  localparam logic [15:0] RST_WORD   = 16'h0000;

  // Field codes.
  localparam logic [2:0] CLR_NONE   = 3'h0;
  localparam logic [2:0] CLR_ON_A   = 3'h1;
  localparam logic [2:0] CLR_ON_B   = 3'h2;
  localparam logic [1:0] EDGE_FALL  = 2'h0;
  localparam logic [1:0] EDGE_RISE  = 2'h1;
  localparam logic [1:0] TRIG_OWN   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [3:0] MODE_NORMAL = 4'h0;

  typedef enum logic [1:0] {
    TPP_IDLE   = 2'b00,
    TPP_ACCESS = 2'b01,
    TPP_DONE   = 2'b10
  } tpp_bus_e;
endpackage

/* testbench/tpp_timer_pulse_chk_sva.sv */
// Port-level assertions for the timer paced pulse block.
`timescale 1ns/1ps
module tpp_timer_pulse_chk
  import tpp_pkg::*;
#(
  parameter int GRP_W = 4
)(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [31:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  input wire logic [31:0]      prdata,
  input wire logic             pslverr,
  input wire logic             timer_pin_a,
  input wire logic             timer_pin_a_oe,
  input wire logic             timer_pin_b,
  input wire logic             timer_pin_b_oe,
  input wire logic [GRP_W-1:0] pulse_out,
  input wire logic [GRP_W-1:0] pulse_out_oe,
  input wire logic             match_a_irq_request
);
  localparam logic [31:0] A_PIN = {6'h0, IDX_PIN_AB, 2'b00};
  logic [3:0] since_wr;
  logic [3:0] since_pin;
  logic       wr_done;
  assign wr_done = psel && penable && pready && pwrite;
  // Saturating ages let an output change be traced to a recent cause.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      since_wr <= 4'hf;
    else if (wr_done)
      since_wr <= 4'h0;
    else if (since_wr != 4'hf)
      since_wr <= since_wr + 4'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      since_pin <= 4'hf;
    else if ($changed(timer_pin_a) || $changed(timer_pin_b))
      since_pin <= 4'h0;
    else if (since_pin != 4'hf)
      since_pin <= since_pin + 4'h1;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held");
  property p_rdy_lat; psel && !penable |-> ##2 (pready && penable); endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("pready late");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");
  property p_rd_idle; !pready |-> prdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("prdata not idle");
  property p_flag_clr; $fell(match_a_irq_request) |-> since_wr <= 4'h3;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("request dropped without a write");
  property p_irq_cause;
    $rose(match_a_irq_request) |-> since_wr <= 4'h3 || since_pin <= 4'h2 ||
      $changed(timer_pin_a);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("request rose without match");
  property p_pin_a_init;
    wr_done && paddr == A_PIN && pwdata[3:0] == 4'h7
      |-> ##[1:2] (timer_pin_a && timer_pin_a_oe);
  endproperty
  a_pin_a_init: assert property (p_pin_a_init)
    else $error("pin a not driven high");
  property p_pin_b_init;
    wr_done && paddr == A_PIN && pwdata[7:4] == 4'h7
      |-> ##[1:2] (timer_pin_b && timer_pin_b_oe);
  endproperty
  a_pin_b_init: assert property (p_pin_b_init)
    else $error("pin b not driven high");
  property p_oe_hold; $changed(pulse_out_oe) |-> since_wr <= 4'h3; endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("enable changed alone");
  property p_out_cause;
    $changed(pulse_out) |-> since_wr <= 4'h3 || since_pin <= 4'h2 ||
      $changed(timer_pin_a) || $changed(timer_pin_b);
  endproperty
  a_out_cause: assert property (p_out_cause)
    else $error("output changed without trigger");
  c_irq: cover property ($rose(match_a_irq_request));
  c_pin: cover property ($changed(timer_pin_b));
  c_err: cover property (pslverr);
endmodule // tpp_timer_pulse_chk

/* testbench/tpp_xfer_model.sv */
// Transfer controller model that refills next data on each match A request.
`timescale 1ns/1ps
module tpp_xfer_model
  import tpp_pkg::*;
#(
  parameter int LAG = 0
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        req,
  input  wire logic        gnt,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata,
  output logic             busy
);
  int ptr;
  initial
  begin
    {psel, penable, pwrite, busy} = 4'h0;
    paddr = '0;
    pwdata = '0;
    ptr = 0;
  end
  task automatic xfer(input logic w, input logic [23:0] i, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {6'h0, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    psel <= 1'b0;
    penable <= 1'b0;
    // A released data bus must not keep showing the last byte.
    pwdata <= ~{24'h0, d};
  endtask
  always
  begin
    @(posedge pclk);
    if (presetn && gnt && req === 1'b1)
    begin
      busy <= 1'b1;
      repeat (LAG) @(posedge pclk);
      xfer(1'b0, IDX_FLAGS, 8'h00);
      xfer(1'b1, IDX_FLAGS, 8'h00);
      // fixed byte destination, before match B
      xfer(1'b1, IDX_NEXT_LOW, 8'h11 * ptr[7:0]);
      ptr = (ptr + 1) % 16;
      busy <= 1'b0;
    end
  end
endmodule // tpp_xfer_model

/* testbench/timer_paced_pulse_output_bench.sv */
// Self-checking bench for the timer paced pulse block.
`timescale 1ns/1ps
module timer_paced_pulse_output_bench
  import tpp_pkg::*;
();
  localparam int CA = 31;
  localparam int CB = 63;
  logic        pclk = 1'b0, presetn = 1'b0, gnt = 1'b0;
  logic        b_psel = 1'b0, b_penable = 1'b0, b_pwrite = 1'b0;
  logic [31:0] b_paddr = '0, b_pwdata = '0;
  logic        x_psel, x_penable, x_pwrite, busy;
  logic [31:0] x_paddr, x_pwdata, paddr, pwdata, prdata;
  logic        psel, penable, pwrite, pready, pslverr;
  logic        capture_in_a = 1'b0, capture_in_b = 1'b0;
  logic [3:0]  pstrb = 4'hf, pulse_out, pulse_out_oe, nxt = 4'h0;
  logic        timer_pin_a, timer_pin_a_oe, timer_pin_b, timer_pin_b_oe;
  logic        match_a_irq_request;
  int          error_cnt = 0, num_checks = 0, cyc = 0, t_rd;
  assign psel = gnt ? x_psel : b_psel;
  assign penable = gnt ? x_penable : b_penable;
  assign pwrite = gnt ? x_pwrite : b_pwrite;
  assign paddr = gnt ? x_paddr : b_paddr;
  assign pwdata = gnt ? x_pwdata : b_pwdata;
  always #2 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // Next data as last written by either master, used for expectations.
  always @(posedge pclk)
    if (psel && penable && pready && pwrite
        && paddr == {6'h0, IDX_NEXT_LOW, 2'b00})
      nxt <= pwdata[3:0];
  tpp_timer_pulse dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .capture_in_a, .capture_in_b,
    .timer_pin_a, .timer_pin_a_oe, .timer_pin_b, .timer_pin_b_oe, .pulse_out,
    .pulse_out_oe, .match_a_irq_request);
  tpp_xfer_model #(.LAG(2)) xfer_u (.pclk, .presetn,
    .req(match_a_irq_request), .gnt, .pready, .psel(x_psel),
    .penable(x_penable), .pwrite(x_pwrite), .paddr(x_paddr),
    .pwdata(x_pwdata), .busy);
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e, string m);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, m, s, e);
    end
  endtask
  task automatic tmo();
    error_cnt++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    print_verdict();
  endtask
  task automatic apb(input logic w, input logic [23:0] i, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    b_psel <= 1'b1;
    b_pwrite <= w;
    b_paddr <= {6'h0, i, 2'b00};
    b_pwdata <= d;
    @(posedge pclk);
    b_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      tmo();
    r = prdata;
    e = pslverr;
    t_rd = cyc;
    b_psel <= 1'b0;
    b_penable <= 1'b0;
    b_pwdata <= ~d;
  endtask
  task automatic wr(input logic [23:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, i, d, r, e);
  endtask
  task automatic rd(input logic [23:0] i, output logic [31:0] r);
    logic e;
    apb(1'b0, i, 32'h0, r, e);
  endtask
  task automatic wait_pin(input bit b, output int t);
    logic last;
    int n;
    last = b ? timer_pin_b : timer_pin_a;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while ((b ? timer_pin_b : timer_pin_a) === last && n < 300);
    if (n >= 300)
      tmo();
    t = cyc;
  endtask
  task automatic t_regs();
    logic [23:0] ix [17];
    logic [31:0] r, d;
    logic e;
    ix = '{IDX_TRIG_SEL, IDX_MODE_CTL, IDX_NEN_HIGH, IDX_NEN_LOW, IDX_OUT_LOW,
           IDX_NEXT_LOW, IDX_RUN_CTL, IDX_SYNC_CTL, IDX_CLK_CTL, IDX_OP_MODE,
           IDX_PIN_AB, IDX_PIN_CD, IDX_IRQ_EN, IDX_FLAGS, IDX_COUNT,
           IDX_CMP_A, IDX_CMP_B};
    foreach (ix[k])
    begin
      rd(ix[k], r);
      chk(r, ix[k] == IDX_MODE_CTL ? {24'h0, RST_MODE} : 32'h0, "reset");
    end
    apb(1'b0, 24'hfff63a, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    for (int k = 0; k < 3; k++)
    begin
      d = 32'hffff_a5c3 ^ k;
      wr(IDX_COUNT + 24'(2 * k), d);
      rd(IDX_COUNT + 24'(2 * k), r);
      chk(r, {16'h0, d[15:0]}, "word readback");
    end
  endtask
  task automatic t_count();
    logic [31:0] r1, r2;
    int t1;
    wr(IDX_CLK_CTL, 32'h0);
    wr(IDX_OP_MODE, 32'h0);
    wr(IDX_SYNC_CTL, 32'h0);
    wr(IDX_COUNT, 32'h1234);
    rd(IDX_COUNT, r1);
    rd(IDX_COUNT, r2);
    chk(r2, 32'h1234, "stopped count");
    wr(IDX_RUN_CTL, 32'h1);
    rd(IDX_COUNT, r1);
    t1 = t_rd;
    rd(IDX_COUNT, r2);
    chk(r2 - r1, 32'(t_rd - t1), "count rate");
    wr(IDX_RUN_CTL, 32'h0);
    rd(IDX_COUNT, r1);
    rd(IDX_COUNT, r2);
    chk(r2, r1, "count halted");
  endtask
  task automatic t_pulse();
    logic [3:0] en, ex, pv;
    logic [31:0] r;
    int t, ta, n;
    en = 4'hb;
    ex = 4'h4;
    wr(IDX_TRIG_SEL, {30'h0, TRIG_OWN});
    wr(IDX_NEN_LOW, 32'hb);
    wr(IDX_OUT_LOW, 32'h4);
    wr(IDX_NEXT_LOW, 32'hf);
    wr(IDX_MODE_CTL, 32'h11);
    wr(IDX_CLK_CTL, {24'h0, CLR_ON_B, EDGE_FALL, 3'h0});
    wr(IDX_CMP_A, CA);
    wr(IDX_CMP_B, CB);
    wr(IDX_IRQ_EN, 32'h1);
    wr(IDX_COUNT, 32'h0);
    wr(IDX_PIN_AB, 32'h77);
    repeat (2) @(posedge pclk);
    pv = {timer_pin_a, timer_pin_a_oe, timer_pin_b, timer_pin_b_oe};
    chk(pv, 4'hf, "pins");
    chk(pulse_out, ex, "initial output");
    chk(pulse_out_oe, en, "output enables");
    wr(IDX_RUN_CTL, 32'h1);
    chk(match_a_irq_request, 1'b0, "quiet at handover");
    gnt <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      wait_pin(1'b0, t);
      ex = (ex & ~en) | (nxt & en);
      if (k > 0)
        chk(t - ta, CB + 1, "period");
      ta = t;
      repeat (3) @(posedge pclk);
      chk(pulse_out, ex, "match a");
      wait_pin(1'b1, t);
      ex = ex & ~(en & ~nxt);
      chk(t - ta, CB - CA, "a to b");
      repeat (3) @(posedge pclk);
      chk(pulse_out, ex, "match b");
    end
    n = 0;
    while (busy !== 1'b0 && n < 60)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 60)
      tmo();
    chk(match_a_irq_request, 1'b0, "quiet at release");
    gnt <= 1'b0;
    n = 0;
    while (match_a_irq_request !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200)
      tmo();
    ex = (ex & ~en) | (nxt & en);
    wr(IDX_RUN_CTL, 32'h0);
    rd(IDX_FLAGS, r);
    chk(r[0], 1'b1, "flag set");
    chk(match_a_irq_request, 1'b1, "request up");
    wr(IDX_FLAGS, 32'h0);
    rd(IDX_FLAGS, r);
    chk(r[0], 1'b0, "flag cleared");
    chk(match_a_irq_request, 1'b0, "request down");
    wr(IDX_MODE_CTL, 32'h01);
    repeat (3) @(posedge pclk);
    chk(pulse_out, ex ^ 4'hf, "inverted");
    wr(IDX_TRIG_SEL, 32'h4);
    wr(IDX_NEXT_LOW, 32'h5a);
    wr(IDX_NEXT_ALT, 32'h3c);
    rd(IDX_NEXT_LOW, r);
    chk(r, 32'h5c, "split next data");
  endtask
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_count();
    t_pulse();
    print_verdict();
  end
endmodule // timer_paced_pulse_output_bench
bind tpp_timer_pulse tpp_timer_pulse_chk #(.GRP_W(GRP_W)) chk_u (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
  .pslverr, .timer_pin_a, .timer_pin_a_oe, .timer_pin_b, .timer_pin_b_oe,
  .pulse_out, .pulse_out_oe, .match_a_irq_request);
